// ==== inc/pmb_pkg.sv ====
// Command map, reset values and carrier types for the command register bank.
// Assumes one system clock; the bus pins are sampled by that clock.
package pmb_pkg;

  typedef enum logic [2:0] {
    XF_NONE, XF_SEND, XF_RD_BYTE, XF_RD_WORD, XF_RW_BYTE, XF_RW_WORD,
    XF_RW_BLOCK
  } pmb_xfer_e;

  typedef struct packed {
    logic valid;
    pmb_xfer_e xfer;
    logic locked;
    logic [15:0] rst;
  } pmb_cmd_s;

  typedef struct packed {
    logic [15:0] summary_status_word;
    logic [7:0] output_voltage_status;
    logic [7:0] output_current_status;
    logic [7:0] input_status;
    logic [7:0] thermal_status;
    logic [7:0] comms_logic_status;
    logic [15:0] input_voltage_reading;
    logic [15:0] output_voltage_reading;
    logic [15:0] output_current_reading;
    logic [15:0] temperature_reading;
  } pmb_tele_s;

  typedef struct packed {
    logic [7:0] operation_control;
    logic [7:0] remote_switch_config;
    logic [15:0] output_setpoint;
  } pmb_ctrl_s;

  localparam logic [7:0] C_OPERATION = 8'h01;
  localparam logic [7:0] C_REMOTE_SWITCH = 8'h02;
  localparam logic [7:0] C_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] C_OUT_FORMAT = 8'h20;
  localparam logic [7:0] C_SETPOINT = 8'h21;
  localparam logic [7:0] C_SUMMARY = 8'h79;
  localparam logic [7:0] C_VOUT_STAT = 8'h7A;
  localparam logic [7:0] C_IOUT_STAT = 8'h7B;
  localparam logic [7:0] C_INPUT_STAT = 8'h7C;
  localparam logic [7:0] C_THERM_STAT = 8'h7D;
  localparam logic [7:0] C_COMMS_STAT = 8'h7E;
  localparam logic [7:0] C_VIN_READ = 8'h88;
  localparam logic [7:0] C_VOUT_READ = 8'h8B;
  localparam logic [7:0] C_IOUT_READ = 8'h8C;
  localparam logic [7:0] C_TEMP_READ = 8'h8D;
  localparam logic [7:0] C_PROTO_VER = 8'h98;
  localparam logic [7:0] C_KIND_LOCK = 8'hD0;
  localparam logic [7:0] C_FW_VER = 8'hDB;
  localparam logic [7:0] C_ALERT_SETUP = 8'hE0;
  localparam logic [7:0] C_GOOD_POL = 8'hE2;
  localparam logic [7:0] C_DATE_BLOCK = 8'hF0;

  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0C;
  localparam logic [7:0] BLK_COUNT = 8'h0C;
  localparam int BLK_BYTES = 12;
  localparam logic [3:0] BLK_LAST_IDX = 4'hC;
  localparam int ALERT_BIT = 4;
  localparam int LOCK_BIT = 1;
  localparam logic [15:0] SWITCH_RST_NEG = 16'h001D;
  localparam logic [15:0] SWITCH_RST_POS = 16'h001F;
  localparam logic GOOD_POL_RST = 1'b1;
  localparam logic LOCK_RST = 1'b1;
  localparam logic [4:0] ALERT_SETUP_RST = 5'h00;
  localparam logic [7:0] OUT_FORMAT_VAL = 8'h14;
  localparam logic [7:0] PROTO_VER_VAL = 8'h42;
  // Arbitrary identity values
  localparam logic [5:0] MODULE_NAME = 6'h21;
  localparam logic [15:0] FW_VERSION = 16'h0A0B;

  function automatic pmb_cmd_s pmb_cmd_info(input logic [7:0] c);
    pmb_cmd_s r;
    r = '{1'b1, XF_RW_WORD, 1'b0, 16'h0000};
    case (c)
      8'h01: r.rst = 16'h0088;
      8'h02: r.xfer = XF_RW_BYTE;
      8'h03, 8'h11, 8'h12: r.xfer = XF_SEND;
      8'h20: r = '{1'b1, XF_RD_BYTE, 1'b0, 16'h0014};
      8'h21, 8'h23, 8'h25, 8'h26, 8'h28, 8'h35, 8'h36, 8'h40, 8'h46,
      8'h4A, 8'h4F, 8'h51, 8'h55, 8'h5E, 8'h5F, 8'h60, 8'h61,
      8'hD0: r.xfer = XF_RW_WORD;
      8'h41, 8'h50: r = '{1'b1, XF_RW_BYTE, 1'b0, 16'h00B8};
      8'h47: r = '{1'b1, XF_RW_BYTE, 1'b0, 16'h00F8};
      8'h56: r = '{1'b1, XF_RW_BYTE, 1'b0, 16'h00C0};
      8'h79, 8'h88, 8'h8B, 8'h8C, 8'h8D, 8'hDB: r.xfer = XF_RD_WORD;
      8'h7A, 8'h7B, 8'h7C, 8'h7D, 8'h7E, 8'h98: r.xfer = XF_RD_BYTE;
      8'hD1: r = '{1'b1, XF_RW_WORD, 1'b1, 16'h2000};
      8'hD2, 8'hD3, 8'hD4, 8'hD6, 8'hD7: r.locked = 1'b1;
      8'hE0, 8'hE2: r.xfer = XF_RW_BYTE;
      8'hF0: r = '{1'b1, XF_RW_BLOCK, 1'b1, 16'h0000};
      default: r = '{1'b0, XF_NONE, 1'b0, 16'h0000};
    endcase
    return r;
  endfunction

endpackage

// ==== logic/pmb_cmd_bank.sv ====
// Command register bank behind the two-wire management port.
// Assumes bus clock and data arrive from pins in another domain; telemetry,
// alert request and power-good level come from logic on clk.
// Operation
// RULE_01: Alert setup bit clear: strapped address only.
// RULE_02: Alert setup bit set: alert address only; code does so only while alerting, else strapped address answers.
// RULE_03: Polarity 0: pin low means output good.
// RULE_04: Polarity 1: pin high means output good.
// RULE_05: Only polarity bit 0 writable, resets 0x01.
// RULE_06: Date/site/serial block is exactly 12 bytes.
// RULE_07: Locked commands ignore writes while lock on.
// RULE_08: Remote switch config resets per logic variant.
// RULE_09: Lock enable bit 1 of kind register gates.
// RULE_10: Unlisted code or wrong transfer is invalid.
`timescale 1ns/1ps
module pmb_cmd_bank #(
  parameter bit NEG_LOGIC = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic [6:0] addr_strap_pin,
  input wire logic alert_req,
  output logic alert_pin_out,
  output logic alert_pin_oe,
  input wire logic power_good_in,
  output logic power_ok_pin,
  input wire pmb_pkg::pmb_tele_s tele,
  output pmb_pkg::pmb_ctrl_s ctrl,
  output logic clear_faults
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_CMD, ST_WDATA, ST_RDATA, ST_SKIP
  } pmb_st_e;

  logic [1:0] scl_sy_r, sda_sy_r;
  logic [6:0] strap_m_r, strap_r;
  logic scl_d_r, sda_d_r;
  pmb_st_e st_r;
  logic [3:0] bc_r, idx_r;
  logic [7:0] sh_r, tx_r, cmd_r;
  logic ack_r, ara_rd_r, inv_r, lock_r, pol_r, rst_seen_r;
  logic [4:0] ara_r;
  logic [7:0] wbuf_r [0:12];
  logic [7:0] blk_r [0:pmb_pkg::BLK_BYTES-1];
  logic [15:0] word_mem_r [0:255];

  logic scl, sda, scl_rise, scl_fall, start_det, stop_det;
  logic recv_st, byte_done, addr_done, addr_match, ara_sel, readable;
  logic tx_load, wr_evt, len_ok, do_wr, do_send, bad_wr, inv_set;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  pmb_pkg::pmb_cmd_s info;
  pmb_pkg::pmb_cmd_s sh_info;

  // Two flops on every pin before any logic looks at it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      strap_m_r <= 7'h00;
      strap_r <= 7'h00;
    end else begin
      scl_sy_r <= {scl_sy_r[0], scl_pin};
      sda_sy_r <= {sda_sy_r[0], sda_pin_in};
      scl_d_r <= scl_sy_r[1];
      sda_d_r <= sda_sy_r[1];
      strap_m_r <= addr_strap_pin;
      strap_r <= strap_m_r;
    end
  end

  assign scl = scl_sy_r[1];
  assign sda = sda_sy_r[1];
  assign scl_rise = scl & ~scl_d_r;
  assign scl_fall = ~scl & scl_d_r;
  assign start_det = scl & scl_d_r & sda_d_r & ~sda;
  assign stop_det = scl & scl_d_r & ~sda_d_r & sda;

  assign info = pmb_pkg::pmb_cmd_info(cmd_r);
  assign sh_info = pmb_pkg::pmb_cmd_info(sh_r);
  assign readable = (info.xfer != pmb_pkg::XF_NONE) &&
                    (info.xfer != pmb_pkg::XF_SEND);
  assign recv_st = (st_r == ST_ADDR) || (st_r == ST_CMD) ||
                   (st_r == ST_WDATA);
  assign byte_done = scl_fall && !ack_r && recv_st && (bc_r == 4'h8);
  assign addr_done = byte_done && (st_r == ST_ADDR);
  assign ara_sel = alert_pin_oe && ara_r[pmb_pkg::ALERT_BIT] &&
                   (sh_r[7:1] == pmb_pkg::ALERT_RESP_ADDR);
  // While alerting with the setup bit on, the strapped address goes deaf
  assign addr_match = (alert_pin_oe && ara_r[pmb_pkg::ALERT_BIT]) ?
                      ara_sel : (sh_r[7:1] == strap_r); // RULE_01 RULE_02
  assign tx_load = scl_fall && (st_r == ST_RDATA) &&
                   (ack_r || (bc_r == 4'h9));

  always_comb begin
    case (info.xfer)
      pmb_pkg::XF_RW_BYTE: len_ok = (idx_r == 4'h1);
      pmb_pkg::XF_RW_WORD: len_ok = (idx_r == 4'h2);
      pmb_pkg::XF_RW_BLOCK: len_ok = (idx_r == 4'hD) &&
                              (wbuf_r[0] == pmb_pkg::BLK_COUNT); // RULE_06
      default: len_ok = 1'b0;
    endcase
  end

  assign wr_evt = stop_det && (st_r == ST_WDATA);
  // Locked writes vanish without a flag; software cannot tell
  assign do_wr = wr_evt && len_ok && !(info.locked && lock_r); // RULE_07 RULE_09
  assign do_send = wr_evt && (info.xfer == pmb_pkg::XF_SEND) &&
                   (idx_r == 4'h0);
  assign bad_wr = wr_evt && (idx_r != 4'h0) && info.valid && !len_ok;
  assign inv_set = (byte_done && (st_r == ST_CMD) &&
                    !sh_info.valid) || bad_wr ||
                   (addr_done && addr_match && sh_r[0] && !ara_sel &&
                    !readable); // RULE_10

  always_comb begin
    case (cmd_r)
      pmb_pkg::C_OUT_FORMAT: rd_word = {8'h00, pmb_pkg::OUT_FORMAT_VAL};
      pmb_pkg::C_SUMMARY: rd_word = tele.summary_status_word;
      pmb_pkg::C_VOUT_STAT: rd_word = {8'h00, tele.output_voltage_status};
      pmb_pkg::C_IOUT_STAT: rd_word = {8'h00, tele.output_current_status};
      pmb_pkg::C_INPUT_STAT: rd_word = {8'h00, tele.input_status};
      pmb_pkg::C_THERM_STAT: rd_word = {8'h00, tele.thermal_status};
      pmb_pkg::C_COMMS_STAT: rd_word = {8'h00,
                                        tele.comms_logic_status | {inv_r, 7'h00}};
      pmb_pkg::C_VIN_READ: rd_word = tele.input_voltage_reading;
      pmb_pkg::C_VOUT_READ: rd_word = tele.output_voltage_reading;
      pmb_pkg::C_IOUT_READ: rd_word = tele.output_current_reading;
      pmb_pkg::C_TEMP_READ: rd_word = tele.temperature_reading;
      pmb_pkg::C_PROTO_VER: rd_word = {8'h00, pmb_pkg::PROTO_VER_VAL};
      pmb_pkg::C_KIND_LOCK: rd_word = {8'h00, pmb_pkg::MODULE_NAME,
                                       lock_r, 1'b0};
      pmb_pkg::C_FW_VER: rd_word = pmb_pkg::FW_VERSION;
      pmb_pkg::C_ALERT_SETUP: rd_word = {11'h000, ara_r};
      pmb_pkg::C_GOOD_POL: rd_word = {15'h0000, pol_r}; // RULE_05
      default: rd_word = word_mem_r[cmd_r];
    endcase
  end

  always_comb begin
    rd_byte = 8'hFF;
    if (ara_rd_r) begin
      if (idx_r == 4'h0) begin
        rd_byte = {strap_r, 1'b0};
      end
    end else begin
      case (info.xfer)
        pmb_pkg::XF_RD_BYTE, pmb_pkg::XF_RW_BYTE: begin
          if (idx_r == 4'h0) rd_byte = rd_word[7:0];
        end
        pmb_pkg::XF_RD_WORD, pmb_pkg::XF_RW_WORD: begin
          if (idx_r == 4'h0) rd_byte = rd_word[7:0];
          else if (idx_r == 4'h1) rd_byte = rd_word[15:8];
        end
        pmb_pkg::XF_RW_BLOCK: begin
          if (idx_r == 4'h0) rd_byte = pmb_pkg::BLK_COUNT; // RULE_06
          else if (idx_r <= pmb_pkg::BLK_LAST_IDX) rd_byte = blk_r[idx_r - 4'h1];
        end
        default: rd_byte = 8'hFF;
      endcase
    end
  end

  // Byte engine: samples on bus clock rise, drives data after its fall
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= ST_IDLE;
      bc_r <= 4'h0;
      idx_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      cmd_r <= 8'h00;
      ack_r <= 1'b0;
      ara_rd_r <= 1'b0;
      sda_pin_oe <= 1'b0;
      for (int i = 0; i < 13; i++) wbuf_r[i] <= 8'h00;
    end else if (start_det) begin
      st_r <= ST_ADDR;
      bc_r <= 4'h0;
      ack_r <= 1'b0;
      ara_rd_r <= 1'b0;
      sda_pin_oe <= 1'b0;
    end else if (stop_det) begin
      st_r <= ST_IDLE;
      ack_r <= 1'b0;
      sda_pin_oe <= 1'b0;
    end else if (scl_rise) begin
      if (recv_st && (bc_r < 4'h8)) begin
        sh_r <= {sh_r[6:0], sda};
        bc_r <= 4'(bc_r + 4'h1);
      end else if ((st_r == ST_RDATA) && (bc_r == 4'h9) && sda) begin
        st_r <= ST_SKIP;
      end
    end else if (scl_fall) begin
      if (tx_load) begin
        ack_r <= 1'b0;
        sda_pin_oe <= ~rd_byte[7];
        tx_r <= {rd_byte[6:0], 1'b0};
        bc_r <= 4'h1;
        idx_r <= (idx_r == 4'hF) ? 4'hF : 4'(idx_r + 4'h1);
      end else if (ack_r) begin
        ack_r <= 1'b0;
        bc_r <= 4'h0;
        sda_pin_oe <= 1'b0;
      end else if (st_r == ST_RDATA) begin
        if (bc_r < 4'h8) begin
          sda_pin_oe <= ~tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
          bc_r <= 4'(bc_r + 4'h1);
        end else begin
          sda_pin_oe <= 1'b0;
          bc_r <= 4'h9;
        end
      end else if (byte_done) begin
        case (st_r)
          ST_ADDR: begin
            if (addr_match) begin // RULE_01 RULE_02
              ack_r <= 1'b1;
              sda_pin_oe <= 1'b1;
              ara_rd_r <= ara_sel;
              idx_r <= 4'h0;
              st_r <= sh_r[0] ? ST_RDATA : ST_CMD;
            end else begin
              st_r <= ST_SKIP;
            end
          end
          ST_CMD: begin
            ack_r <= 1'b1;
            sda_pin_oe <= 1'b1;
            cmd_r <= sh_r;
            idx_r <= 4'h0;
            st_r <= ST_WDATA;
          end
          ST_WDATA: begin
            ack_r <= 1'b1;
            sda_pin_oe <= 1'b1;
            if (idx_r < 4'hD) wbuf_r[idx_r] <= sh_r;
            idx_r <= (idx_r == 4'hF) ? 4'hF : 4'(idx_r + 4'h1);
          end
          default: st_r <= ST_SKIP;
        endcase
      end
    end
  end

  // Writable storage; only a full, correctly sized transfer commits at stop
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 256; i++) begin
        // Reset value is the low half-word of the packed info
        word_mem_r[i] <= 16'(pmb_pkg::pmb_cmd_info(8'(i)));
      end
      word_mem_r[pmb_pkg::C_REMOTE_SWITCH] <= NEG_LOGIC ?
        pmb_pkg::SWITCH_RST_NEG : pmb_pkg::SWITCH_RST_POS; // RULE_08
      for (int i = 0; i < pmb_pkg::BLK_BYTES; i++) blk_r[i] <= 8'h00;
      lock_r <= pmb_pkg::LOCK_RST;
      ara_r <= pmb_pkg::ALERT_SETUP_RST;
      pol_r <= pmb_pkg::GOOD_POL_RST; // RULE_05
    end else if (do_wr) begin
      case (cmd_r)
        pmb_pkg::C_DATE_BLOCK: begin
          for (int i = 0; i < pmb_pkg::BLK_BYTES; i++) blk_r[i] <= wbuf_r[i+1];
        end
        pmb_pkg::C_KIND_LOCK: lock_r <= wbuf_r[0][pmb_pkg::LOCK_BIT]; // RULE_09
        pmb_pkg::C_ALERT_SETUP: ara_r <= wbuf_r[0][4:0];
        pmb_pkg::C_GOOD_POL: pol_r <= wbuf_r[0][0]; // RULE_05
        default: begin
          word_mem_r[cmd_r] <= (info.xfer == pmb_pkg::XF_RW_BYTE) ?
                               {8'h00, wbuf_r[0]} : {wbuf_r[1], wbuf_r[0]};
        end
      endcase
    end
  end

  // A new invalid event beats a clear arriving in the same cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      inv_r <= 1'b0;
    end else if (inv_set) begin
      inv_r <= 1'b1; // RULE_10
    end else if (do_send && (cmd_r == pmb_pkg::C_CLEAR_FAULTS)) begin
      inv_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_ok_pin <= 1'b0;
      alert_pin_out <= 1'b0;
      alert_pin_oe <= 1'b0;
      sda_pin_out <= 1'b0;
      clear_faults <= 1'b0;
      ctrl <= '0;
      rst_seen_r <= 1'b0;
    end else begin
      power_ok_pin <= ~(power_good_in ^ pol_r); // RULE_03 RULE_04
      alert_pin_oe <= alert_req;
      clear_faults <= do_send && (cmd_r == pmb_pkg::C_CLEAR_FAULTS);
      ctrl <= {word_mem_r[pmb_pkg::C_OPERATION][7:0],
               word_mem_r[pmb_pkg::C_REMOTE_SWITCH][7:0],
               word_mem_r[pmb_pkg::C_SETPOINT]};
      rst_seen_r <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_strap_only;
    addr_done && !ara_r[pmb_pkg::ALERT_BIT] && (sh_r[7:1] == strap_r)
      |=> sda_pin_oe && (st_r != ST_SKIP) ##1 sda_pin_oe;
  endproperty
  a_strap_only: assert property (p_strap_only) // RULE_01
    else $error("strapped address not answered");

  property p_ara_only;
    addr_done && alert_pin_oe && ara_r[pmb_pkg::ALERT_BIT] &&
      (sh_r[7:1] != pmb_pkg::ALERT_RESP_ADDR) |=> !sda_pin_oe && st_r == ST_SKIP;
  endproperty
  a_ara_only: assert property (p_ara_only) // RULE_02
    else $error("answered other address while alert routing on");

  property p_pol_low;
    !pol_r |=> power_ok_pin == !$past(power_good_in);
  endproperty
  a_pol_low: assert property (p_pol_low) // RULE_03
    else $error("negative polarity pin wrong");

  property p_pol_high;
    pol_r |=> power_ok_pin == $past(power_good_in);
  endproperty
  a_pol_high: assert property (p_pol_high) // RULE_04
    else $error("positive polarity pin wrong");

  property p_pol_reg;
    (!rst_seen_r |-> pol_r) and
    ((cmd_r == pmb_pkg::C_GOOD_POL) |-> rd_word[15:1] == 15'h0000);
  endproperty
  a_pol_reg: assert property (p_pol_reg) // RULE_05
    else $error("polarity register reset or reserved bits wrong");

  property p_block_count;
    tx_load && !ara_rd_r && (info.xfer == pmb_pkg::XF_RW_BLOCK) &&
      (idx_r == 4'h0) |=> sda_pin_oe == ~pmb_pkg::BLK_COUNT[7] &&
      tx_r == {pmb_pkg::BLK_COUNT[6:0], 1'b0};
  endproperty
  a_block_count: assert property (p_block_count) // RULE_06
    else $error("block read count not 12");

  property p_locked;
    wr_evt && info.locked && lock_r |=> $stable(blk_r[0]) &&
      $stable(word_mem_r[cmd_r]);
  endproperty
  a_locked: assert property (p_locked) // RULE_07
    else $error("locked command was written");

  property p_switch_rst;
    !rst_seen_r |-> word_mem_r[pmb_pkg::C_REMOTE_SWITCH] ==
      (NEG_LOGIC ? pmb_pkg::SWITCH_RST_NEG : pmb_pkg::SWITCH_RST_POS);
  endproperty
  a_switch_rst: assert property (p_switch_rst) // RULE_08
    else $error("remote switch config reset wrong");

  property p_unlocked;
    wr_evt && len_ok && info.locked && !lock_r &&
      (info.xfer == pmb_pkg::XF_RW_WORD)
      |=> word_mem_r[cmd_r] == {wbuf_r[1], wbuf_r[0]};
  endproperty
  a_unlocked: assert property (p_unlocked) // RULE_09
    else $error("unlocked write not stored");

  property p_invalid;
    byte_done && (st_r == ST_CMD) && !sh_info.valid
      |-> ##[1:2] inv_r;
  endproperty
  a_invalid: assert property (p_invalid) // RULE_10
    else $error("unlisted code not flagged");

endmodule // pmb_cmd_bank

// ==== test/pmb_cmd_bank_test.sv ====
// Self-checking bench for the command register bank.
// Assumes the host model in its own file and the package in inc/.
`timescale 1ns/1ps
module pmb_cmd_bank_test;
  localparam logic [6:0] STRAP = 7'h5A;
  localparam int LIMIT = 90000;
  logic clk, resetn, scl, sda_low, sda_wire, sda_pin_out, sda_pin_oe;
  logic alert_req, alert_pin_out, alert_pin_oe, power_good_in;
  logic power_ok_pin, clear_faults, ok;
  logic [6:0] addr_strap_pin;
  pmb_pkg::pmb_tele_s tele;
  pmb_pkg::pmb_ctrl_s ctrl;
  int n_errors = 0, num_checks = 0, n_clear = 0, cyc = 0;
  assign sda_wire = ~(sda_low | (sda_pin_oe & ~sda_pin_out));
  pmb_cmd_bank #(.NEG_LOGIC(1'b1)) dut (.clk(clk), .resetn(resetn),
    .scl_pin(scl), .sda_pin_in(sda_wire), .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe), .addr_strap_pin(addr_strap_pin),
    .alert_req(alert_req), .alert_pin_out(alert_pin_out),
    .alert_pin_oe(alert_pin_oe), .power_good_in(power_good_in),
    .power_ok_pin(power_ok_pin), .tele(tele), .ctrl(ctrl),
    .clear_faults(clear_faults));
  pmb_host_model h (.clk(clk), .sda_wire(sda_wire), .scl(scl),
    .sda_low(sda_low));
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (clear_faults === 1'b1) n_clear++;
    cyc++;
    if (cyc == LIMIT) begin
      n_errors++;
      $display("BAD t=%0t run too long", $time);
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic put(input logic [7:0] c, input logic [15:0] v, input int n);
    h.buf_b[0] = v[7:0];
    h.buf_b[1] = v[15:8];
    h.xfer(STRAP, c, n, 0, ok);
    chk1(ok, 1'b1);
  endtask
  task automatic get(input logic [7:0] c, input int n, input logic [15:0] e);
    h.xfer(STRAP, c, 0, n, ok);
    chk1(ok, 1'b1);
    chk8(h.buf_b[0], e[7:0]);
    if (n > 1) chk8(h.buf_b[1], e[15:8]);
  endtask
  task automatic blk(input logic [7:0] seed, input int n);
    h.buf_b[0] = n[7:0];
    for (int i = 0; i < n; i++) h.buf_b[i + 1] = seed + 8'(i);
    h.xfer(STRAP, 8'hF0, n + 1, 0, ok);
  endtask
  task automatic blk_chk(input logic [7:0] seed, input logic [7:0] step);
    h.xfer(STRAP, 8'hF0, 0, 13, ok);
    chk8(h.buf_b[0], pmb_pkg::BLK_COUNT);
    for (int i = 0; i < pmb_pkg::BLK_BYTES; i++)
      chk8(h.buf_b[i + 1], seed + step * 8'(i));
  endtask
  task automatic t_reset();
    chk8(ctrl.operation_control, 8'h88);
    chk8(ctrl.remote_switch_config, 8'h1D);
    get(8'h01, 1, 16'h0088);
    get(8'h02, 1, 16'h001D);
    get(8'h20, 1, 16'h0014);
    get(8'h41, 1, 16'h00B8);
    get(8'h47, 1, 16'h00F8);
    get(8'h56, 1, 16'h00C0);
    get(8'hE0, 1, 16'h0000);
    get(8'hE2, 1, 16'h0001);
    get(8'hD1, 2, 16'h2000);
    get(8'hD0, 2, {8'h00, pmb_pkg::MODULE_NAME, 2'b10});
    get(8'h88, 2, 16'hBEEF);
  endtask
  task automatic t_polarity();
    for (int g = 0; g < 2; g++) begin
      power_good_in = g[0];
      wait_clk(3);
      chk1(power_ok_pin, g[0]);
      put(8'hE2, 16'h00FE, 1);
      get(8'hE2, 1, 16'h0000);
      chk1(power_ok_pin, ~g[0]);
      put(8'hE2, 16'h00FF, 1);
      get(8'hE2, 1, 16'h0001);
    end
  endtask
  task automatic t_lock();
    put(8'hD1, 16'h1234, 2);
    get(8'hD1, 2, 16'h2000);
    blk(8'h30, 12);
    blk_chk(8'h00, 8'h00);
    put(8'hD0, 16'h0000, 2);
    get(8'hD0, 2, {8'h00, pmb_pkg::MODULE_NAME, 2'b00});
    put(8'hD1, 16'h1234, 2);
    get(8'hD1, 2, 16'h1234);
    blk(8'h30, 12);
    blk_chk(8'h30, 8'h01);
    blk(8'h50, 3);
    blk_chk(8'h30, 8'h01);
    put(8'hD0, 16'h0002, 2);
    blk(8'h70, 12);
    blk_chk(8'h30, 8'h01);
  endtask
  task automatic t_invalid();
    int n0;
    h.xfer(STRAP, 8'h03, 0, 0, ok);
    get(8'h7E, 1, 16'h0000);
    put(8'hC5, 16'h0000, 1);
    get(8'h7E, 1, 16'h0080);
    n0 = n_clear;
    h.xfer(STRAP, 8'h03, 0, 0, ok);
    chk8(8'(n_clear - n0), 8'h01);
    get(8'h7E, 1, 16'h0000);
    put(8'h20, 16'h0000, 1);
    get(8'h7E, 1, 16'h0080);
    get(8'h20, 1, 16'h0014);
    h.xfer(STRAP, 8'h03, 0, 0, ok);
    put(8'h21, 16'h00AB, 1);
    get(8'h7E, 1, 16'h0080);
    put(8'h21, 16'hABCD, 2);
    get(8'h21, 2, 16'hABCD);
    chk8(ctrl.output_setpoint[15:8], 8'hAB);
    chk8(ctrl.output_setpoint[7:0], 8'hCD);
  endtask
  task automatic t_alert();
    alert_req = 1'b1;
    wait_clk(3);
    chk1(alert_pin_oe, 1'b1);
    chk1(alert_pin_out, 1'b0);
    chk1(sda_pin_out, 1'b0);
    get(8'h01, 1, 16'h0088);
    h.xfer(pmb_pkg::ALERT_RESP_ADDR, -1, 0, 1, ok);
    chk1(ok, 1'b0);
    put(8'hE0, 16'h00FF, 1);
    h.xfer(STRAP, 8'h01, 0, 1, ok);
    chk1(ok, 1'b0);
    h.xfer(pmb_pkg::ALERT_RESP_ADDR, -1, 0, 1, ok);
    chk1(ok, 1'b1);
    chk8(h.buf_b[0], {STRAP, 1'b0});
    alert_req = 1'b0;
    wait_clk(3);
    get(8'hE0, 1, 16'h001F);
    put(8'hE0, 16'h0000, 1);
  endtask
  initial begin
    resetn = 1'b0;
    alert_req = 1'b0;
    power_good_in = 1'b1;
    addr_strap_pin = STRAP;
    tele = '0;
    tele.input_voltage_reading = 16'hBEEF;
    wait_clk(6);
    resetn = 1'b1;
    wait_clk(8);
    t_reset();
    t_polarity();
    t_lock();
    t_invalid();
    t_alert();
    report_and_stop();
  end
endmodule // pmb_cmd_bank_test

// ==== test/pmb_host_model.sv ====
// Bus host model: drives the clock line and pulls the data line low.
// Assumes the bench resolves the data wire with a pull-up and feeds it back.
`timescale 1ns/1ps
module pmb_host_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_low
);
  logic [7:0] buf_b [0:13];
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Quarter bit of 4 clk keeps data changes clear of clock edges
  task automatic q();
    repeat (4) @(posedge clk);
    #1;
  endtask
  // Clock line idles high between frames
  task automatic start();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic stop();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    q();
    sda_low = 1'b0;
    q();
    q();
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    q();
    scl = 1'b1;
    q();
    r = sda_wire;
    q();
    scl = 1'b0;
    q();
  endtask
  task automatic xbyte(input logic [7:0] d, input logic nack,
                       output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(nack, b);
    ack = ~b;
  endtask
  // c below zero: address-only read; nr above zero: read, after a restart unless c is below zero
  task automatic xfer(input logic [6:0] a, input int c, input int nw,
                      input int nr, output logic ok);
    logic [7:0] r;
    logic k;
    ok = 1'b1;
    start();
    if (c >= 0) begin
      xbyte({a, 1'b0}, 1'b1, r, k);
      ok &= k;
      xbyte(c[7:0], 1'b1, r, k);
      ok &= k;
      for (int i = 0; i < nw; i++) begin
        xbyte(buf_b[i], 1'b1, r, k);
        ok &= k;
      end
    end
    if (nr > 0) begin
      if (c >= 0) start();
      xbyte({a, 1'b1}, 1'b1, r, k);
      ok &= k;
      // Last byte gets no acknowledge so the device lets go of the line
      for (int i = 0; i < nr; i++) begin
        xbyte(8'hFF, (i == nr - 1), buf_b[i], k);
      end
    end
    stop();
  endtask
endmodule // pmb_host_model
